// >>> core/sfl_front_end.sv
// Purpose: serial interface front end of a serial NOR flash with register access
// Assumes: hclk 25 MHz; serial_clock_in is the link clock of its own domain
// Notes:   tx_data crosses quasi-statically and is loaded at byte boundaries
`timescale 1ns/1ps
module sfl_front_end
   import sfl_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        serial_clock_in,
   input  wire logic        chip_select_n,
   input  wire logic        serial_in,
   input  wire logic        pause_n,
   input  wire logic        write_protect_n,
   output logic             serial_out,
   output logic             serial_out_en,
   output logic             active_power
);

   typedef enum logic [3:0] {
      SFL_ST_IDLE = 4'b0001,
      SFL_ST_CMD  = 4'b0010,
      SFL_ST_ADDR = 4'b0100,
      SFL_ST_DATA = 4'b1000
   } sfl_state_t;

   // protect code to protected test of a sector
   function automatic logic sect_protected(input logic [2:0] level, input logic [3:0] sect);
      logic hit;
      hit = 1'b0;
      case (level)
         3'h0: hit = 1'b0;
         3'h1: hit = (sect == 4'hF);
         3'h2: hit = (sect >= 4'hE);
         3'h3: hit = (sect >= 4'hC);
         3'h4: hit = (sect >= 4'h8);
         default: hit = 1'b1;
      endcase
      return hit;
   endfunction : sect_protected

   // ---------------- link domain ----------------
   logic [2:0] bit_cnt;
   logic [6:0] rx_shift;
   logic [7:0] rx_byte;
   logic       rx_tgl;
   logic       mid_byte;
   logic [7:0] tx_shift;
   logic       link_idle;
   logic [7:0] tx_data;

   assign link_idle = chip_select_n | ~pause_n;

   // bit counter and input shifter, cleared by deselect
   always_ff @(posedge serial_clock_in or posedge chip_select_n) begin
      if (chip_select_n) begin
         bit_cnt  <= 3'h0;
         rx_shift <= 7'h00;
      end else if (pause_n) begin
         bit_cnt  <= bit_cnt + 3'h1;
         rx_shift <= {rx_shift[5:0], serial_in};
      end
   end

   // completed byte and its event toggle
   always_ff @(posedge serial_clock_in or negedge hresetn) begin
      if (!hresetn) begin
         rx_byte  <= 8'h00;
         rx_tgl   <= 1'b0;
         mid_byte <= 1'b0;
      end else if (!chip_select_n && pause_n) begin
         mid_byte <= (bit_cnt != 3'h7);
         if (bit_cnt == 3'h7) begin
            rx_byte <= {rx_shift, serial_in};
            rx_tgl  <= ~rx_tgl;
         end
      end
   end

   // output shifter on falling edge, floated when deselected or paused
   always_ff @(negedge serial_clock_in or posedge link_idle) begin
      if (link_idle) begin
         serial_out_en <= 1'b0;
         tx_shift      <= 8'h00;
         serial_out    <= 1'b0;
      end else begin
         serial_out_en <= 1'b1;
         if (bit_cnt == 3'h0) begin
            tx_shift   <= {tx_data[6:0], 1'b0};
            serial_out <= tx_data[7];
         end else begin
            tx_shift   <= {tx_shift[6:0], 1'b0};
            serial_out <= tx_shift[7];
         end
      end
   end

   // ---------------- bus domain ----------------
   logic [SYNC_W-1:0] sync1;
   logic [SYNC_W-1:0] sync2;
   logic              cs_late;
   logic              tgl_seen;
   logic              cs_n_s;
   logic              pause_n_s;
   logic              wp_n_s;
   logic              mid_s;
   logic              tgl_s;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1    <= {SYNC_W{1'b1}};
         sync2    <= {SYNC_W{1'b1}};
         cs_late  <= 1'b1;
         tgl_seen <= 1'b0;
      end else begin
         sync1    <= {chip_select_n, pause_n, write_protect_n, mid_byte, rx_tgl};
         sync2    <= sync1;
         cs_late  <= sync2[4];
         tgl_seen <= sync2[0];
      end
   end
   assign cs_n_s    = sync2[4];
   assign pause_n_s = sync2[3];
   assign wp_n_s    = sync2[2];
   assign mid_s     = sync2[1];
   assign tgl_s     = sync2[0];

   logic       cs_fall;
   logic       frame_end;
   logic       byte_evt;
   logic       end_pend;
   logic [1:0] warm;
   logic       primed;

   // edges count only once the synchroniser holds real pin values
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) warm <= 2'h0;
      else if (!primed) warm <= warm + 2'h1;
   end
   assign primed   = (warm == 2'(SYNC_STAGES + 1));
   assign cs_fall  = primed & cs_late & ~cs_n_s;
   assign byte_evt = primed & (tgl_s ^ tgl_seen);
   // frame end judged a cycle later so the last byte event lands first
   assign frame_end = end_pend & ~byte_evt;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) end_pend <= 1'b0;
      else end_pend <= (primed & ~cs_late & cs_n_s) | (end_pend & byte_evt);
   end

   // frame parser
   sfl_state_t         state;
   logic               armed;
   logic [7:0]         opcode;
   logic [1:0]         addr_idx;
   logic [ADDR_W-1:0]  cur_addr;
   logic [COUNT_W-1:0] data_cnt;
   logic [7:0]         last_byte;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         armed <= 1'b0;
      end else if (cs_fall) begin
         armed <= 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state     <= SFL_ST_IDLE;
         opcode    <= 8'h00;
         addr_idx  <= 2'h0;
         cur_addr  <= '0;
         data_cnt  <= '0;
         last_byte <= 8'h00;
      end else if (cs_fall) begin
         state    <= SFL_ST_CMD;
         addr_idx <= 2'h0;
         data_cnt <= '0;
      end else if (frame_end) begin
         state <= SFL_ST_IDLE;
      end else if (byte_evt) begin
         last_byte <= sync2[0] ? rx_byte : rx_byte;
         case (state)
            SFL_ST_CMD: begin
               opcode <= rx_byte;
               state  <= (rx_byte == OPC_BULK_ER) ? SFL_ST_DATA : SFL_ST_ADDR;
            end
            SFL_ST_ADDR: begin
               cur_addr <= {cur_addr[ADDR_W-9:0], rx_byte};
               addr_idx <= addr_idx + 2'h1;
               if (addr_idx == 2'(ADDR_BYTES - 1)) state <= SFL_ST_DATA;
            end
            SFL_ST_DATA: begin
               if (data_cnt != COUNT_MAX) data_cnt <= data_cnt + 9'h001;
            end
            default: state <= SFL_ST_IDLE;
         endcase
      end
   end

   // operation decision at the end of a frame
   logic       busy;
   logic       rejected;
   sfl_op_t    op;
   logic [2:0] level;
   logic       done_wr;
   logic       whole;
   logic       ok_prog;
   logic       ok_sect;
   logic       ok_bulk;

   assign whole   = ~mid_s && (state == SFL_ST_DATA) && armed;
   assign ok_prog = whole && (opcode == OPC_PROGRAM) && (data_cnt != '0) &&
                    !sect_protected(level, cur_addr[ADDR_W-1:SECT_LSB]);
   assign ok_sect = whole && (opcode == OPC_SECT_ER) &&
                    !sect_protected(level, cur_addr[ADDR_W-1:SECT_LSB]);
   assign ok_bulk = whole && (opcode == OPC_BULK_ER) && (level == 3'h0);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         busy     <= 1'b0;
         rejected <= 1'b0;
         op       <= '0;
      end else begin
         if (frame_end && !busy && (ok_prog || ok_sect || ok_bulk)) begin
            busy     <= 1'b1;
            rejected <= 1'b0;
            op.addr  <= cur_addr;
            op.count <= data_cnt;
            if (ok_prog) op.kind <= SFL_OP_PROGRAM;
            else if (ok_sect) op.kind <= SFL_OP_SECT_ER;
            else op.kind <= SFL_OP_BULK_ER;
         end else begin
            if (frame_end && whole && opcode != OPC_READ) rejected <= 1'b1;
            if (done_wr) busy <= 1'b0;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) active_power <= 1'b0;
      else active_power <= ~cs_n_s | busy;
   end

   // ---------------- AHB-Lite slave ----------------
   logic       dp_wr;
   logic [7:0] dp_addr;
   logic       ap_valid;
   assign ap_valid = hsel & hready & htrans[1];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_wr     <= 1'b0;
         dp_addr   <= 8'h00;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         dp_wr     <= ap_valid & hwrite;
         dp_addr   <= haddr[7:0];
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   assign done_wr = dp_wr && (dp_addr == REG_CTRL) && hwdata[CTRL_DONE_BIT];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         level   <= LEVEL_RESET;
         tx_data <= TX_RESET;
      end else if (dp_wr) begin
         if (dp_addr == REG_CTRL) begin
            if (wp_n_s) level <= hwdata[CTRL_LEVEL_LSB +: 3];
         end else if (dp_addr == REG_TXDATA) begin
            tx_data <= hwdata[7:0];
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (ap_valid && !hwrite) begin
         if (haddr[7:0] == REG_CTRL) begin
            hrdata <= {29'h0, level};
         end else if (haddr[7:0] == REG_STATUS) begin
            hrdata <= {25'h0, ~wp_n_s, rejected, active_power, ~pause_n_s & ~cs_n_s,
                       busy, armed, ~cs_n_s};
         end else if (haddr[7:0] == REG_OP) begin
            hrdata <= {21'h0, op.count, op.kind};
         end else if (haddr[7:0] == REG_ADDR) begin
            hrdata <= {12'h0, op.addr};
         end else if (haddr[7:0] == REG_RXDATA) begin
            hrdata <= {24'h0, last_byte};
         end else if (haddr[7:0] == REG_TXDATA) begin
            hrdata <= {24'h0, tx_data};
         end else begin
            hrdata <= 32'h0000_0000;
         end
      end
   end

endmodule : sfl_front_end

// >>> dv/sfl_front_end_bench.sv
// Purpose: self-checking bench of the flash front end
// Assumes: hclk 40 ns, link clock 160 ns from the master model
// Notes:   outcomes read back through the status registers, power and serial output checked at the pins
`timescale 1ns/1ps
module sfl_front_end_bench
   import sfl_pkg::*;
;
   logic        hclk, hresetn, hsel, hwrite, write_protect_n, hreadyout, hresp;
   logic        sck, cs_n, mosi, hold_n, serial_out, serial_out_en, active_power;
   logic [31:0] haddr, hwdata, hrdata, rdv;
   logic [1:0]  htrans;
   logic [7:0]  rx;
   int          error_cnt, n_compared;
   localparam logic [12:0] T_OK = 13'h04A7;
   logic [3:0]  t_sec [13] = '{4'h3, 4'h0, 4'h0, 4'h5, 4'hF, 4'hE, 4'h0,
                                4'hD, 4'hC, 4'h8, 4'h7, 4'h0, 4'h0};
   logic [2:0]  t_lvl [13] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h1, 3'h1,
                                3'h2, 3'h3, 3'h4, 3'h4, 3'h5, 3'h7};
   sfl_front_end sfl_front_end_inst (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .serial_clock_in(sck),
      .chip_select_n(cs_n), .serial_in(mosi), .pause_n(hold_n),
      .write_protect_n(write_protect_n), .serial_out(serial_out),
      .serial_out_en(serial_out_en), .active_power(active_power));
   sfl_spi_master sfl_spi_master_inst (
      .sck(sck), .cs_n(cs_n), .mosi(mosi), .hold_n(hold_n), .miso(serial_out));
   initial begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end
   task automatic end_of_test();
      $display("errors %0d compared %0d", error_cnt, n_compared);
      if (error_cnt == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : end_of_test
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      int i;
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      i = 0;
      do begin
         @(posedge hclk);
         i++;
      end while (hreadyout !== 1'b1 && i < 40);
      htrans <= 2'h0;
      hwdata <= wd;
      do begin
         @(posedge hclk);
         i++;
      end while (hreadyout !== 1'b1 && i < 80);
      rdv = hrdata;
      if (i >= 80) begin
         error_cnt++;
         end_of_test();
      end
   endtask : ahb
   task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] e);
      ahb(1'b0, a, 32'h0);
      chk(nm, e, rdv & m);
   endtask : rchk
   task automatic frame(input logic fresh, input logic [7:0] opc, input logic [19:0] adr,
                        input int nd);
      if (fresh) sfl_spi_master_inst.open_frame(1'b0);
      sfl_spi_master_inst.shift(opc, 8, rx);
      for (int k = 2; k >= 0 && opc != OPC_BULK_ER; k--)
         sfl_spi_master_inst.shift(8'(adr >> 8 * k), 8, rx);
      for (int k = 0; k < nd; k++) begin
         sfl_spi_master_inst.shift(8'h5A ^ 8'(k), 8, rx);
         if (k == 0) sfl_spi_master_inst.pause_bits();
      end
      sfl_spi_master_inst.close_frame();
      repeat (8) @(posedge hclk);
   endtask : frame
   initial begin
      logic [1:0] kind;
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      write_protect_n = 1'b1;
      error_cnt = 0;
      n_compared = 0;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      rchk("ctrl", REG_CTRL, 32'hF, 32'h0);
      rchk("txdata", REG_TXDATA, 32'hFF, 32'hFF);
      rchk("unmapped", 8'h18, 32'hFFFFFFFF, 32'h0);
      rchk("status", REG_STATUS, 32'h26, 32'h0);
      frame(1'b0, OPC_PROGRAM, 20'h0, 1);
      rchk("busy", REG_STATUS, 32'h4, 32'h0);
      for (int i = 0; i < 13; i++) begin
         kind = (i == 2 || i == 3) ? 2'h1 : (i == 1 || i == 6) ? 2'h3 : 2'h2;
         ahb(1'b1, REG_CTRL, {29'h0, t_lvl[i]});
         frame(1'b1, kind == 2'h1 ? OPC_PROGRAM : kind == 2'h2 ? OPC_SECT_ER : OPC_BULK_ER,
               {t_sec[i], 16'h12FF}, int'(i == 2));
         rchk("busy", REG_STATUS, 32'h4, {29'h0, T_OK[i], 2'h0});
         chk("power", {31'h0, T_OK[i]}, {31'h0, active_power});
         if (!T_OK[i]) rchk("rejected", REG_STATUS, 32'h20, 32'h20);
         else rchk("op", REG_OP, 32'h3, {30'h0, kind});
         if (T_OK[i] && kind != 2'h3)
            rchk("addr", REG_ADDR, 32'hFFFFF, {12'h0, t_sec[i], 16'h12FF});
         ahb(1'b1, REG_CTRL, {28'h0, 1'b1, t_lvl[i]});
      end
      ahb(1'b1, REG_CTRL, 32'h0);
      frame(1'b1, OPC_PROGRAM, 20'hFFF00, 257);
      rchk("op", REG_OP, 32'h7FF, {21'h0, COUNT_MAX, 2'h1});
      rchk("addr", REG_ADDR, 32'hFFFFF, 32'hFFF00);
      rchk("rxdata", REG_RXDATA, 32'hFF, 32'h5A);
      ahb(1'b1, REG_CTRL, 32'h8);
      rchk("busy", REG_STATUS, 32'h4, 32'h0);
      chk("power", 32'h0, {31'h0, active_power});
      write_protect_n <= 1'b0;
      repeat (4) @(posedge hclk);
      ahb(1'b1, REG_CTRL, 32'h5);
      rchk("ctrl", REG_CTRL, 32'h7, 32'h0);
      write_protect_n <= 1'b1;
      sfl_spi_master_inst.open_frame(1'b0);
      sfl_spi_master_inst.shift(OPC_SECT_ER, 8, rx);
      sfl_spi_master_inst.shift(8'h20, 4, rx);
      sfl_spi_master_inst.close_frame();
      rchk("rejected", REG_STATUS, 32'h24, 32'h0);
      frame(1'b1, OPC_SECT_ER, 20'h212FF, 0);
      rchk("addr", REG_ADDR, 32'hFFFFF, 32'h212FF);
      sfl_spi_master_inst.open_frame(1'b0);
      sfl_spi_master_inst.pause_bits();
      sfl_spi_master_inst.close_frame();
      rchk("busy", REG_STATUS, 32'h24, 32'h4);
      ahb(1'b1, REG_CTRL, 32'h8);
      ahb(1'b1, REG_TXDATA, 32'hA5);
      sfl_spi_master_inst.open_frame(1'b1);
      for (int k = 0; k < 5; k++)
         sfl_spi_master_inst.shift(k == 0 ? OPC_READ : 8'h00, 8, rx);
      chk("serial_out", 32'hA5, {24'h0, rx});
      sfl_spi_master_inst.close_frame();
      chk("out_en", 32'h0, {31'h0, serial_out_en});
      end_of_test();
   end
endmodule : sfl_front_end_bench

// >>> dv/sfl_front_end_monitor.sv
// Purpose: bus and pin assertions of the flash front end
// Assumes: hclk domain and serial_clock_in domain
// Notes:   bound to sfl_front_end
`timescale 1ns/1ps
module sfl_front_end_monitor (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic        serial_clock_in,
   input wire logic        chip_select_n,
   input wire logic        pause_n,
   input wire logic        serial_out,
   input wire logic        serial_out_en,
   input wire logic        active_power
);
   sequence s_addr_rd;
      hsel && hready && htrans[1] && !hwrite;
   endsequence
   sequence s_sel_held;
      $fell(chip_select_n) ##1 (!chip_select_n)[*5];
   endsequence
   a_resp_okay: assert property (@(posedge hclk) disable iff (!hresetn)
      hresp == 1'b0) else $error("hresp not okay");
   a_zero_wait: assert property (@(posedge hclk) disable iff (!hresetn)
      hreadyout == 1'b1) else $error("wait state inserted");
   a_unmapped_zero: assert property (@(posedge hclk) disable iff (!hresetn)
      s_addr_rd ##0 (haddr[7:0] > 8'h14) |=> hrdata == 32'h0)
      else $error("unmapped read not zero");
   a_rdata_stand: assert property (@(posedge hclk) disable iff (!hresetn)
      !(hsel && hready && htrans[1] && !hwrite) |=> $stable(hrdata))
      else $error("read data changed without read");
   a_float_desel: assert property (@(posedge hclk) disable iff (!hresetn)
      chip_select_n |-> !serial_out_en) else $error("output driven while deselected");
   a_float_pause: assert property (@(posedge hclk) disable iff (!hresetn)
      !pause_n |-> !serial_out_en) else $error("output driven during pause");
   a_active_sel: assert property (@(posedge hclk) disable iff (!hresetn)
      s_sel_held |-> active_power) else $error("selected but not active");
   a_out_edge: assert property (@(serial_clock_in)
      disable iff (chip_select_n || !pause_n || !hresetn)
      serial_clock_in && serial_out_en && $past(serial_out_en) |-> $stable(serial_out))
      else $error("output changed while clock high");
endmodule : sfl_front_end_monitor
bind sfl_front_end sfl_front_end_monitor sfl_front_end_monitor_inst (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
   .hresp(hresp), .serial_clock_in(serial_clock_in), .chip_select_n(chip_select_n),
   .pause_n(pause_n), .serial_out(serial_out), .serial_out_en(serial_out_en),
   .active_power(active_power));

// >>> dv/sfl_spi_master.sv
// Purpose: spi bus master model for the flash front end
// Assumes: link clock period 160 ns, still between frames
// Notes:   cpol selects mode 0 or mode 3
`timescale 1ns/1ps
module sfl_spi_master (
   output logic      sck,
   output logic      cs_n,
   output logic      mosi,
   output logic      hold_n,
   input  wire logic miso
);
   logic cpol;
   initial begin
      cpol = 1'b0;
      sck = 1'b0;
      cs_n = 1'b0;
      mosi = 1'b0;
      hold_n = 1'b1;
   end
   task automatic open_frame(input logic pol);
      cpol = pol;
      sck = pol;
      #7;
      cs_n = 1'b0;
      #80;
   endtask : open_frame
   task automatic shift(input logic [7:0] tx, input int n, output logic [7:0] rx);
      for (int i = 7; i > 7 - n; i--) begin
         sck = 1'b0;
         mosi = tx[i];
         #80;
         sck = 1'b1;
         rx = {rx[6:0], miso};
         #80;
      end
      mosi = ~mosi;
   endtask : shift
   task automatic pause_bits();
      hold_n = 1'b0;
      repeat (6) begin
         #80;
         sck = ~sck;
         mosi = ~mosi;
      end
      #80;
      hold_n = 1'b1;
      #80;
   endtask : pause_bits
   task automatic close_frame();
      sck = cpol;
      #80;
      cs_n = 1'b1;
      #400;
   endtask : close_frame
endmodule : sfl_spi_master

// >>> include/sfl_pkg.sv
// Purpose: shared constants and types of the serial flash front end
// Assumes: 32-bit AHB-Lite register bus, one aligned word per register
// Notes:   opcodes and register offsets are local choices
package sfl_pkg;
   // array organisation
   localparam int SECTOR_COUNT   = 16;
   localparam int PAGES_PER_SECT = 256;
   localparam int PAGE_BYTES     = 256;
   localparam int ADDR_W         = 20;
   localparam int SECT_LSB       = 16;
   localparam int PAGE_LSB       = 8;
   localparam int COUNT_W        = 9;
   localparam logic [COUNT_W-1:0] COUNT_MAX = 9'h100;
   // command opcodes
   localparam logic [7:0] OPC_PROGRAM = 8'h02;
   localparam logic [7:0] OPC_READ    = 8'h03;
   localparam logic [7:0] OPC_SECT_ER = 8'hD8;
   localparam logic [7:0] OPC_BULK_ER = 8'hC7;
   localparam int ADDR_BYTES = 3;
   // register byte offsets
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_OP     = 8'h08;
   localparam logic [7:0] REG_ADDR   = 8'h0C;
   localparam logic [7:0] REG_RXDATA = 8'h10;
   localparam logic [7:0] REG_TXDATA = 8'h14;
   // control fields
   localparam int CTRL_LEVEL_LSB = 0;
   localparam int CTRL_DONE_BIT  = 3;
   // status fields
   localparam int ST_SELECTED = 0;
   localparam int ST_ARMED    = 1;
   localparam int ST_BUSY     = 2;
   localparam int ST_PAUSED   = 3;
   localparam int ST_ACTIVE   = 4;
   localparam int ST_REJECTED = 5;
   localparam int ST_WPROT    = 6;
   // reset values and synchroniser sizes
   localparam logic [2:0] LEVEL_RESET = 3'h0;
   localparam logic [7:0] TX_RESET    = 8'hFF;
   localparam int SYNC_STAGES = 2;
   localparam int SYNC_W      = 5;

   typedef enum logic [1:0] {
      SFL_OP_NONE    = 2'h0,
      SFL_OP_PROGRAM = 2'h1,
      SFL_OP_SECT_ER = 2'h2,
      SFL_OP_BULK_ER = 2'h3
   } sfl_op_kind_t;

   typedef struct packed {
      sfl_op_kind_t             kind;
      logic [ADDR_W-1:0]        addr;
      logic [COUNT_W-1:0]       count;
   } sfl_op_t;
endpackage : sfl_pkg
